// ### verification/bfc_flash_model.sv
// Behavioural four-bank page-mode flash seen by the host controller.
`timescale 1ns/10ps
`include "bfc_defs.svh"
// ----------------------------------------------------------------------------
// Flash model
// ----------------------------------------------------------------------------
module bfc_flash_model #(
  // Arbitrary identification value.
  parameter logic [15:0] AS_CODE = 16'h3C5A,
  parameter int          PROG_NS = 3000,
  parameter int          ERASE_NS = 6000
) (
  // Flash pins
  input  wire logic [20:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic [15:0]      dq_o,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rst_n_i,
  input  wire logic        hv_i,
  output logic             ryby_n_o
);
  logic [15:0] mem [logic [20:0]];
  logic [15:0] last = 16'h0;
  logic [20:0] a_q = 21'h0;
  logic        opn = 1'b0;
  logic        act = 1'b0;
  logic        asel = 1'b0;
  logic [2:0]  bb = 3'h0;
  int          st = 0, busy_t = 0, t = 0, need = 70, wr_cnt = 0, bad_cnt = 0;
  function automatic logic [1:0] bank(input logic [20:0] a);
    bank = (a[20:18] == 3'h0) ? 2'h0 : (a[20:18] == 3'h7) ? 2'h3 : a[20] ? 2'h2 : 2'h1;
  endfunction
  // array unless busy bank or autoselect
  function automatic logic [15:0] rd(input logic [20:0] a);
    if (busy_t > 0 && (bb[2] || bb[1:0] == bank(a))) rd = 16'h0080;
    else if (asel) rd = AS_CODE;
    else if (mem.exists(a)) rd = mem[a];
    else rd = ~a[15:0];
  endfunction
  // busy while working or in reset
  assign ryby_n_o = !(busy_t > 0 || !rst_n_i);
  always #1 begin
    if (busy_t > 0) busy_t--;
    if (!rst_n_i) begin st = 0; asel = 1'b0; busy_t = 0; end
    if (!rst_n_i || ce_n_i || oe_n_i) begin
      dq_o = ~last;
      act = 1'b0;
      if (ce_n_i || !rst_n_i) opn = 1'b0;
    end else begin
      if (!act || addr_i != a_q) begin
        need = (opn && addr_i[20:2] == a_q[20:2]) ? `BFC_T_PACC_NS : `BFC_T_ACC_NS;
        a_q = addr_i; t = 0; act = 1'b1;
      end
      t++;
      if (t >= need) begin dq_o = rd(addr_i); last = dq_o; opn = 1'b1; end
      else dq_o = ~last;
    end
  end
  always @(posedge we_n_i) begin
    if (!ce_n_i && rst_n_i) begin
      wr_cnt++;
      if (!oe_n_i) bad_cnt++;
      if (dq_i == `BFC_CMD_RESET) begin st = 0; asel = 1'b0; end
      else case (st)
        0: st = (dq_i == `BFC_UNLOCK1_DATA && addr_i == `BFC_UNLOCK1_ADDR) ? 1 :
                (hv_i && dq_i == `BFC_CMD_PROG) ? 3 : 0;
        1: st = (dq_i == `BFC_UNLOCK2_DATA && addr_i == `BFC_UNLOCK2_ADDR) ? 2 : 0;
        2: begin
          st = (dq_i == `BFC_CMD_PROG) ? 3 : (dq_i == `BFC_CMD_ERASE) ? 4 : 0;
          if (dq_i == `BFC_CMD_AUTOSEL) asel = 1'b1;
        end
        // words below 0x1000 guarded without high voltage
        3: begin
          if (addr_i[20:12] != 9'h0 || hv_i) mem[addr_i] = dq_i;
          busy_t = PROG_NS; bb = {1'b0, bank(addr_i)}; st = 0;
        end
        4: st = (dq_i == `BFC_UNLOCK1_DATA) ? 5 : 0;
        5: st = (dq_i == `BFC_UNLOCK2_DATA) ? 6 : 0;
        default: begin
          st = 0;
          for (int k = 0; k < 32768; k++) begin
            if (dq_i == `BFC_CMD_CHIP || dq_i == `BFC_CMD_SECTOR)
              mem[(dq_i == `BFC_CMD_CHIP) ? 21'(k * 64) : {addr_i[20:15], 15'(k)}] = 16'hFFFF;
          end
          busy_t = ERASE_NS; bb = {dq_i == `BFC_CMD_CHIP, bank(addr_i)};
        end
      endcase
    end
  end
endmodule // bfc_flash_model

// ### verification/bfc_host_tb_top.sv
// Self-checking bench of the flash host controller against the flash model.
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module bfc_host_tb_top
  import bfc_pkg::*;
;
  localparam logic [15:0] AS = 16'h3C5A;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, acc = 1'b0;
  logic rdy, rv, busy, foe, ce_n, oe_n, we_n, frst_n, hv, ryby_n;
  bfc_op_t op = BFC_OP_READ;
  logic [20:0] addr = 21'h0, fa;
  logic [15:0] wdat = 16'h0, rdat, fdi, fdo;
  logic [1:0]  bank;
  int error_cnt = 0, cmp_count = 0;
  always #4 clk = ~clk;
  bfc_host u_dut (.clk_sys_i(clk), .resetn_i(rst_n), .req_valid_i(vld), .req_ready_o(rdy),
    .req_op_i(op), .req_addr_i(addr), .req_data_i(wdat), .accel_i(acc), .rsp_valid_o(rv),
    .rsp_data_o(rdat), .flash_busy_o(busy), .rsp_bank_o(bank), .address_bus_o(fa),
    .data_bus_i(fdi), .data_bus_o(fdo), .data_bus_oe_o(foe), .flash_ce_n_o(ce_n),
    .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_reset_n_o(frst_n),
    .protect_accel_in_hv_o(hv), .ready_busy_n_i(ryby_n));
  bfc_flash_model #(.AS_CODE(AS)) u_flash (.addr_i(fa), .dq_i(fdo), .dq_o(fdi),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .rst_n_i(frst_n), .hv_i(hv),
    .ryby_n_o(ryby_n));
  task automatic give_verdict;
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // Waits for ready, issues one request and collects any read answer.
  task automatic req(input bfc_op_t o, input logic [20:0] a, input logic [15:0] d,
                     output logic [15:0] g, output logic [1:0] gb);
    int n;
    n = 0;
    g = 16'hx;
    gb = 2'hx;
    while (rdy !== 1'b1 && n < 3000) begin step(1); n++; end
    op = o; addr = a; wdat = d; vld = 1'b1;
    step(1);
    vld = 1'b0;
    while (rdy !== 1'b1 && n < 3000) begin
      if (rv === 1'b1) begin g = rdat; gb = bank; end
      step(1);
      n++;
    end
    if (n >= 3000) chk(16'h1, 16'h0, "ready timeout");
  endtask
  task automatic rd(input logic [20:0] a, input logic [15:0] e);
    logic [15:0] g;
    logic [1:0]  b;
    req(BFC_OP_READ, a, 16'h0, g, b);
    chk(g, e, "read data");
  endtask
  task automatic wr(input bfc_op_t o, input logic [20:0] a, input logic [15:0] d,
                    input logic [15:0] cyc);
    logic [15:0] g;
    logic [1:0]  b;
    int w;
    w = u_flash.wr_cnt;
    req(o, a, d, g, b);
    chk(16'(u_flash.wr_cnt - w), cyc, "write cycles");
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin step(1); n++; end
    chk({15'h0, busy}, 16'h0, "still busy");
  endtask
  task automatic t_banks;
    logic [1:0]  eb [8];
    logic [15:0] g;
    logic [1:0]  b;
    eb = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
    for (int i = 0; i < 8; i++) begin
      req(BFC_OP_READ, {i[2:0], 18'h00404}, 16'h0, g, b);
      chk(g, 16'hFBFB, "bank data");
      chk({14'h0, b}, {14'h0, eb[i]}, "bank");
    end
  endtask
  task automatic t_page;
    logic [15:0] g;
    logic [1:0]  b;
    for (int i = 0; i < 4; i++) rd(21'h030004 + 21'(i), ~(16'h0004 + 16'(i)));
    rd(21'h030006, 16'hFFF9);
    rd(21'h030008, 16'hFFF7);
    req(BFC_OP_ARRAY, 21'h030009, 16'h0, g, b);
    chk(g, 16'hFFF6, "array read");
  endtask
  task automatic t_prog;
    wr(BFC_OP_PROG, 21'h001100, 16'h1234, 16'h4);
    chk({15'h0, foe}, 16'h0, "data bus released");
    step(4);
    chk({15'h0, busy}, 16'h1, "busy");
    rd(21'h1C0040, 16'hFFBF);
    wait_idle;
    rd(21'h001100, 16'h1234);
    wr(BFC_OP_PROG, 21'h000020, 16'h0000, 16'h4);
    wait_idle;
    rd(21'h000020, 16'hFFDF);
  endtask
  task automatic t_accel;
    acc = 1'b1;
    step(4);
    wr(BFC_OP_PROG, 21'h000010, 16'h5A5A, 16'h2);
    chk({15'h0, hv}, 16'h1, "high voltage on");
    wait_idle;
    acc = 1'b0;
    step(4);
    chk({15'h0, hv}, 16'h0, "high voltage off");
    rd(21'h000010, 16'h5A5A);
  endtask
  task automatic t_auto;
    wr(BFC_OP_AUTOSEL, 21'h000000, 16'h0, 16'h3);
    rd(21'h000001, AS);
    wr(BFC_OP_RESET, 21'h000000, 16'h0, 16'h1);
    rd(21'h012345, 16'hDCBA);
    wr(BFC_OP_AUTOSEL, 21'h000000, 16'h0, 16'h3);
    rst_n = 1'b0;
    step(6);
    rst_n = 1'b1;
    step(20);
    chk({15'h0, frst_n}, 16'h0, "flash reset");
    chk({15'h0, busy}, 16'h1, "busy in reset");
    rd(21'h012345, 16'hDCBA);
  endtask
  task automatic t_erase;
    wr(BFC_OP_SECTOR, 21'h001100, 16'h0, 16'h6);
    wait_idle;
    rd(21'h001104, 16'hFFFF);
    rd(21'h1C0040, 16'hFFBF);
    wr(BFC_OP_CHIP, 21'h000000, 16'h0, 16'h6);
    wait_idle;
    rd(21'h1C0040, 16'hFFFF);
  endtask
  initial begin
    step(6);
    rst_n = 1'b1;
    rd(21'h012345, 16'hDCBA);
    t_page;
    t_banks;
    t_prog;
    t_accel;
    t_auto;
    t_erase;
    chk(16'(u_flash.bad_cnt), 16'h0, "strobe clash");
    give_verdict;
  end
  // The run needs about 27 us; the limit leaves ample margin.
  initial begin
    #200000;
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule // bfc_host_tb_top

// ### verilog/bfc_defs.svh
// Timing counts, field positions and command constants of the flash host controller.
`ifndef BFC_DEFS_SVH
`define BFC_DEFS_SVH
// ----------------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------------
`define BFC_ADDR_W        21
`define BFC_DATA_W        16
`define BFC_BANK_HI       20
`define BFC_BANK_LO       18
`define BFC_WORD_HI       1
`define BFC_PAGE_LO       2
// ----------------------------------------------------------------------------
// Timing in nanoseconds and derived cycles at 125 MHz
// ----------------------------------------------------------------------------
`define BFC_CLK_NS        8
`define BFC_T_ACC_NS      70
`define BFC_T_PACC_NS     25
`define BFC_T_WP_NS       40
`define BFC_T_RP_NS       500
`define BFC_ACC_CYC       ((`BFC_T_ACC_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_PACC_CYC      ((`BFC_T_PACC_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_WP_CYC        ((`BFC_T_WP_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_RP_CYC        ((`BFC_T_RP_NS + `BFC_CLK_NS - 1) / `BFC_CLK_NS)
`define BFC_CNT_W         8
// ----------------------------------------------------------------------------
// Command words
// ----------------------------------------------------------------------------
`define BFC_UNLOCK1_ADDR  21'h000555
`define BFC_UNLOCK2_ADDR  21'h0002AA
`define BFC_UNLOCK1_DATA  16'h00AA
`define BFC_UNLOCK2_DATA  16'h0055
`define BFC_CMD_PROG      16'h00A0
`define BFC_CMD_ERASE     16'h0080
`define BFC_CMD_CHIP      16'h0010
`define BFC_CMD_SECTOR    16'h0030
`define BFC_CMD_AUTOSEL   16'h0090
`define BFC_CMD_RESET     16'h00F0
`endif

// ### verilog/bfc_host.sv
// Host controller that drives a four-bank page-mode NOR flash over its pins.
// ----------------------------------------------------------------------------
// Notes on behaviour
// R1: Reads drive chip select and output gate low, write strobe high, valid address.
// R2: After power-up or reset the flash reads array data without command.
// R3: Banks return array data until a written command changes the latch.
// R4: Address bits above bit 1 pick a page; bits 1..0 pick the word.
// R5: Same-page reads are faster; deselecting closes the page.
// R6: Reads of one bank are allowed while another bank programs or erases.
// R7: Bank decodes from top three address bits: 000 A, 001-011 B, 100-110 C, 111 D.
// R8: Write cycles drive write strobe and chip select low, output gate high.
// R9: Accelerated program takes two write cycles instead of four.
// R10: High voltage on protect_accel_in enters accelerated program and unprotects.
// R11: High voltage only for accelerated programming; otherwise held high. The host applies it to any request made while accel_i is high.
// R12: Erase acts on one sector or the whole device.
// R13: Autoselect command sequence makes reads return identification codes.
// R14: In standby the data outputs float regardless of output gate.
// R15: Standby when chip select and reset high; next read takes full access.
// R16: Deselecting during program or erase does not stop it.
// R17: Reset low ends operations, floats outputs, returns to array read.
// R18: ready_busy_n low while busy or resetting, high when ready.
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`include "bfc_defs.svh"
module bfc_host
  import bfc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    resetn_i,
  // User request
  input  wire logic                    req_valid_i,
  output logic                         req_ready_o,
  input  wire bfc_op_t                 req_op_i,
  input  wire logic [`BFC_ADDR_W-1:0]  req_addr_i,
  input  wire logic [`BFC_DATA_W-1:0]  req_data_i,
  input  wire logic                    accel_i,
  // User answer
  output logic                         rsp_valid_o,
  output logic [`BFC_DATA_W-1:0]       rsp_data_o,
  output logic                         flash_busy_o,
  output logic [1:0]                   rsp_bank_o,
  // Flash pins
  output logic [`BFC_ADDR_W-1:0]       address_bus_o,
  input  wire logic [`BFC_DATA_W-1:0]  data_bus_i,
  output logic [`BFC_DATA_W-1:0]       data_bus_o,
  output logic                         data_bus_oe_o,
  output logic                         flash_ce_n_o,
  output logic                         flash_oe_n_o,
  output logic                         flash_we_n_o,
  output logic                         flash_reset_n_o,
  output logic                         protect_accel_in_hv_o,
  input  wire logic                    ready_busy_n_i
);
  // --------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------------------
  logic rst_a_r;
  logic rst_n;
  logic rdy_s;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_a_r <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n   <= rst_a_r;
    end
  end
  bfc_sync u_rdy_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .d_i       (ready_busy_n_i),
    .q_o       (rdy_s)
  );
  logic [`BFC_DATA_W-1:0] din_m_r;
  logic [`BFC_DATA_W-1:0] din_s_r;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      din_m_r <= 16'h0000;
      din_s_r <= 16'h0000;
    end else begin
      din_m_r <= data_bus_i;
      din_s_r <= din_m_r;
    end
  end
  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  localparam logic [`BFC_CNT_W-1:0] ACC_C  = `BFC_CNT_W'(`BFC_ACC_CYC + 2);
  localparam logic [`BFC_CNT_W-1:0] PACC_C = `BFC_CNT_W'(`BFC_PACC_CYC + 2);
  localparam logic [`BFC_CNT_W-1:0] WP_C   = `BFC_CNT_W'(`BFC_WP_CYC);
  localparam logic [`BFC_CNT_W-1:0] RP_C   = `BFC_CNT_W'(`BFC_RP_CYC);
  bfc_state_t              st_r, st_nxt;
  logic [`BFC_CNT_W-1:0]   cnt_r, cnt_nxt;
  logic [2:0]              step_r, step_nxt;
  logic [2:0]              nstep_r, nstep_nxt;
  bfc_op_t                 op_r, op_nxt;
  logic [`BFC_ADDR_W-1:0]  addr_r, addr_nxt;
  logic [`BFC_DATA_W-1:0]  data_r, data_nxt;
  logic [`BFC_DATA_W-1:0]  rdata_r, rdata_nxt;
  logic                    page_open_r, page_open_nxt;
  logic [`BFC_ADDR_W-3:0]  page_r, page_nxt;
  logic                    hv_r, hv_nxt;
  logic                    rvld_r, rvld_nxt;
  logic [`BFC_ADDR_W-1:0]  wa;
  logic [`BFC_DATA_W-1:0]  wd;
  logic [1:0]              bank;
  // R7: bank decode
  always_comb begin
    unique case (addr_r[`BFC_BANK_HI:`BFC_BANK_LO])
      3'b000:                bank = BFC_BANK_A;
      3'b001, 3'b010, 3'b011: bank = BFC_BANK_B;
      3'b100, 3'b101, 3'b110: bank = BFC_BANK_C;
      3'b111:                bank = BFC_BANK_D;
    endcase
  end
  // R8: command cycle table
  always_comb begin
    wa = addr_r;
    wd = data_r;
    unique case (op_r)
      BFC_OP_PROG: begin
        // R9: accelerated drops unlocks
        if (nstep_r == 3'd2 && step_r == 3'd0) begin
          wd = `BFC_CMD_PROG;
        end else if (nstep_r == 3'd4 && step_r == 3'd2) begin
          wa = `BFC_UNLOCK1_ADDR;
          wd = `BFC_CMD_PROG;
        end else if (nstep_r == 3'd4 && step_r < 3'd2) begin
          wa = step_r[0] ? `BFC_UNLOCK2_ADDR : `BFC_UNLOCK1_ADDR;
          wd = step_r[0] ? `BFC_UNLOCK2_DATA : `BFC_UNLOCK1_DATA;
        end
      end
      // R12: erase unlocks twice
      // R13: autoselect three cycles
      BFC_OP_SECTOR, BFC_OP_CHIP, BFC_OP_AUTOSEL: begin
        unique case (step_r)
          3'd0, 3'd3: begin
            wa = `BFC_UNLOCK1_ADDR;
            wd = `BFC_UNLOCK1_DATA;
          end
          3'd1, 3'd4: begin
            wa = `BFC_UNLOCK2_ADDR;
            wd = `BFC_UNLOCK2_DATA;
          end
          3'd2: begin
            wa = `BFC_UNLOCK1_ADDR;
            wd = (op_r == BFC_OP_AUTOSEL) ? `BFC_CMD_AUTOSEL : `BFC_CMD_ERASE;
          end
          default: begin
            wa = (op_r == BFC_OP_CHIP) ? `BFC_UNLOCK1_ADDR : addr_r;
            wd = (op_r == BFC_OP_CHIP) ? `BFC_CMD_CHIP : `BFC_CMD_SECTOR;
          end
        endcase
      end
      default: begin
        wd = `BFC_CMD_RESET;
      end
    endcase
  end
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    nstep_nxt = nstep_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    rdata_nxt = rdata_r;
    page_open_nxt = page_open_r;
    page_nxt = page_r;
    hv_nxt = hv_r;
    rvld_nxt = 1'b0;
    unique case (st_r)
      BFC_ST_IDLE: begin
        if (req_valid_i) begin
          op_nxt = req_op_i;
          addr_nxt = req_addr_i;
          data_nxt = req_data_i;
          step_nxt = 3'd0;
          // R10: accelerated mode follows the high-voltage request
          hv_nxt = accel_i;
          if (req_op_i == BFC_OP_READ || req_op_i == BFC_OP_ARRAY) begin
            st_nxt = BFC_ST_READ;
            // R5: same open page gives the short page access time
            cnt_nxt = (page_open_r && page_r == req_addr_i[`BFC_ADDR_W-1:`BFC_PAGE_LO])
                      ? PACC_C : ACC_C;
            page_nxt = req_addr_i[`BFC_ADDR_W-1:`BFC_PAGE_LO];
          end else begin
            st_nxt = BFC_ST_WRITE;
            cnt_nxt = WP_C;
            // R15: chip select rises after the sequence, so the page closes
            page_open_nxt = 1'b0;
            unique case (req_op_i)
              // R9: two cycles with accelerated program, four otherwise
              BFC_OP_PROG:    nstep_nxt = accel_i ? 3'd2 : 3'd4;
              // R12: sector or whole-device erase sequences
              BFC_OP_SECTOR,
              BFC_OP_CHIP:    nstep_nxt = 3'd6;
              // R13: autoselect entry
              BFC_OP_AUTOSEL: nstep_nxt = 3'd3;
              BFC_OP_RESET:   nstep_nxt = 3'd1;
              default:        nstep_nxt = 3'd1;
            endcase
          end
        end else if (!accel_i) begin
          // R11: high voltage removed while idle with no request once accel_i is low
          hv_nxt = 1'b0;
        end
      end
      BFC_ST_READ: begin
        // R3: reads issue no command
        if (cnt_r == 8'h00) begin
          rdata_nxt = din_s_r;
          rvld_nxt = 1'b1;
          page_open_nxt = 1'b1;
          st_nxt = BFC_ST_RDONE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      BFC_ST_RDONE: begin
        st_nxt = BFC_ST_IDLE;
      end
      BFC_ST_WRITE: begin
        if (cnt_r == 8'h00) begin
          st_nxt = BFC_ST_GAP;
          cnt_nxt = WP_C;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      BFC_ST_GAP: begin
        if (cnt_r == 8'h00) begin
          step_nxt = step_r + 3'd1;
          if (step_r + 3'd1 == nstep_r) begin
            st_nxt = BFC_ST_IDLE;
          end else begin
            st_nxt = BFC_ST_WRITE;
            cnt_nxt = WP_C;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      BFC_ST_RESET: begin
        // R17: hold the flash reset pin low for the pulse width
        page_open_nxt = 1'b0;
        if (cnt_r == 8'h00) begin
          st_nxt = BFC_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: st_nxt = BFC_ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= BFC_ST_RESET;
      cnt_r <= RP_C;
      step_r <= 3'd0;
      nstep_r <= 3'd1;
      op_r <= BFC_OP_READ;
      addr_r <= 21'h000000;
      data_r <= 16'h0000;
      rdata_r <= 16'h0000;
      page_open_r <= 1'b0;
      page_r <= 19'h00000;
      hv_r <= 1'b0;
      rvld_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
      nstep_r <= nstep_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      rdata_r <= rdata_nxt;
      page_open_r <= page_open_nxt;
      page_r <= page_nxt;
      hv_r <= hv_nxt;
      rvld_r <= rvld_nxt;
    end
  end
  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  // R2: after the reset pulse the first read needs no command.
  // R6: reads stay allowed while the flash reports busy; only the user may pick the bank.
  assign req_ready_o = (st_r == BFC_ST_IDLE);
  assign rsp_valid_o = rvld_r;
  assign rsp_data_o = rdata_r;
  assign rsp_bank_o = bank;
  // R18: busy follows the synchronised ready/busy pin
  assign flash_busy_o = ~rdy_s;
  // R1: read strobes
  // R4: the whole address goes out; the low two bits pick the word
  // R16: chip select rises after a sequence; the flash finishes on its own
  assign address_bus_o = (st_r == BFC_ST_WRITE || st_r == BFC_ST_GAP) ? wa : addr_r;
  // R5: open page holds select
  // Chip select spans the gap so it never rises together with the write strobe.
  assign flash_ce_n_o = ~(st_r == BFC_ST_READ || st_r == BFC_ST_WRITE || st_r == BFC_ST_GAP
                          || page_open_r);
  assign flash_oe_n_o = ~(st_r == BFC_ST_READ);
  assign flash_we_n_o = ~(st_r == BFC_ST_WRITE);
  assign data_bus_o = wd;
  // R14: the host never drives the data bus outside write cycles
  assign data_bus_oe_o = (st_r == BFC_ST_WRITE || st_r == BFC_ST_GAP);
  assign flash_reset_n_o = (st_r != BFC_ST_RESET);
  assign protect_accel_in_hv_o = hv_r;
  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_read_strobes: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R1
    !flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o) else $error("Read strobes wrong.");
  a_write_strobes: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R8
    !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && data_bus_oe_o)
    else $error("Write strobes wrong.");
  a_no_contention: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R14
    !(data_bus_oe_o && !flash_oe_n_o)) else $error("Bus contention.");
  a_rsp_after_rd: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R5
    $rose(flash_oe_n_o) |-> rsp_valid_o) else $error("Read answer missing.");
  a_accel_two: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R9
    (st_r == BFC_ST_IDLE && req_valid_i && req_op_i == BFC_OP_PROG && accel_i)
    |=> nstep_r == 3'd2) else $error("Accelerated program not two cycles.");
  a_hv_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R11
    (st_r == BFC_ST_IDLE && !req_valid_i && !accel_i) |=> !hv_r)
    else $error("High voltage left on.");
  a_bank_decode: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R7
    addr_r[20:18] == 3'b111 |-> rsp_bank_o == 2'b11) else $error("Bank decode wrong.");
  a_busy_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R18
    $fell(ready_busy_n_i) |-> ##2 flash_busy_o) else $error("Busy not reported.");
endmodule // bfc_host

// ### verilog/bfc_pkg.sv
// Types of the flash host controller.
package bfc_pkg;
  typedef enum logic [2:0] {
    BFC_OP_READ    = 3'b000,
    BFC_OP_PROG    = 3'b001,
    BFC_OP_SECTOR  = 3'b010,
    BFC_OP_CHIP    = 3'b011,
    BFC_OP_AUTOSEL = 3'b100,
    BFC_OP_RESET   = 3'b101,
    BFC_OP_ARRAY   = 3'b110
  } bfc_op_t;
  typedef enum logic [2:0] {
    BFC_ST_IDLE    = 3'b000,
    BFC_ST_READ    = 3'b001,
    BFC_ST_WRITE   = 3'b010,
    BFC_ST_GAP     = 3'b011,
    BFC_ST_RESET   = 3'b100,
    BFC_ST_RDONE   = 3'b101
  } bfc_state_t;
  typedef enum logic [1:0] {
    BFC_BANK_A = 2'b00,
    BFC_BANK_B = 2'b01,
    BFC_BANK_C = 2'b10,
    BFC_BANK_D = 2'b11
  } bfc_bank_t;
endpackage

// ### verilog/bfc_sync.sv
// Two-flip-flop synchroniser for one pin input.
`timescale 1ns/10ps
module bfc_sync (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // Data
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  logic q_r;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b1;
      q_r    <= 1'b1;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end
  assign q_o = q_r;
endmodule // bfc_sync
